// [vrc_pkg.sv]
// Purpose: Shared constants, types and the toggle-pulse synchroniser for the read-config block
// Assumes: Serial link is single line, MSB first, mode 0 sampling
// Notes:   Package first, then the small synchroniser module
package vrc_pkg;
  localparam int          CMD_W        = 8;
  localparam int          ADDR_W       = 24;
  localparam int          CNT_W        = 5;
  localparam logic [7:0]  OP_WR_VCFG   = 8'h81;
  localparam logic [7:0]  OP_RD_VCFG   = 8'h85;
  localparam logic [7:0]  OP_FAST_RD   = 8'h0B;
  localparam logic [7:0]  OP_TUNE_RD   = 8'h5B;
  localparam logic [7:0]  TUNE_BYTE    = 8'h35;
  localparam logic [3:0]  DUMMY_DEF_CD = 4'hF;
  localparam logic [3:0]  DUMMY_ZERO   = 4'h0;
  localparam logic [4:0]  DUMMY_DEF_N  = 5'h08;
  localparam int          DUMMY_LSB    = 4;
  localparam int          XIP_BIT      = 3;
  localparam int          RSVD_BIT     = 2;
  localparam logic [1:0]  WRAP_16      = 2'h0;
  localparam logic [1:0]  WRAP_32      = 2'h1;
  localparam logic [1:0]  WRAP_64      = 2'h2;
  localparam logic [1:0]  WRAP_CONT    = 2'h3;
  localparam logic [7:0]  VCFG_RESET   = 8'hFB;
  localparam int          NV_DUMMY_LSB = 12;
  localparam int          NV_XIP_LSB   = 9;
  localparam logic [2:0]  NV_XIP_OFF   = 3'h7;
  localparam int          NV_DUAL_BIT  = 2;
  localparam int          NV_QUAD_BIT  = 3;

  typedef struct packed {
    logic [3:0] dummy;
    logic       xip_off;
    logic       rsvd;
    logic [1:0] wrap;
  } vrc_cfg_t;

  typedef enum logic [2:0] {
    ST_CMD   = 3'h0,
    ST_ADDR  = 3'h1,
    ST_DUMMY = 3'h2,
    ST_DATA  = 3'h3,
    ST_WREG  = 3'h4,
    ST_RREG  = 3'h5,
    ST_TUNE  = 3'h6,
    ST_IGN   = 3'h7
  } vrc_state_t;
endpackage

`timescale 1ns/1ps
// Toggle to pulse: two flops, then edge detect on the second
module vrc_tog_sync (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic tgl_in,
  output logic      pulse_out
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= tgl_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign pulse_out = sync_q ^ prev_q;
endmodule

// [vrc_volatile_read_config.sv]
// Purpose: Volatile read-settings register with serial write/read and fast read
// Assumes: Host clocks link in mode 0; link clock runs a few edges during reset
// Notes:   Operating configuration lives on clock_in, link logic on link_clk_in
// Operation
// - Completed register write is copied into operating configuration on the third clock_in edge, after the toggle synchroniser.
// - Bits 7:4 give dummy cycles after fast reads, codes 1 to 14.
// - Dummy code zero behaves as all ones, the default count.
// - Bit 3 low enables execute in place; high, the default, disables.
// - Bits 1:0 pick 16, 32, 64 byte wrap or continuous default.
// - Wrap modes increment within the aligned block, then return to start.
// - Continuous mode increments through the whole array while clocked.
// - Nonvolatile bits 2 and 3 both zero select four-line protocol.
// - Device supplies a fixed tuning pattern for sample point adjustment.
// - Reset release loads dummy and execute-in-place fields from the nonvolatile register; wrap goes to continuous.
`timescale 1ns/1ps
module vrc_volatile_read_config #(
  parameter int ADDR_W = vrc_pkg::ADDR_W
) (
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  input  wire logic [15:0]       nv_cfg_in,
  input  wire logic              link_clk_in,
  input  wire logic              cs_n_in,
  input  wire logic              si_in,
  output logic                   so_out,
  output logic                   so_oe_out,
  output logic [ADDR_W-1:0]      mem_addr_out,
  input  wire logic [7:0]        mem_data_in,
  output logic [3:0]             dummy_cycles_out,
  output logic                   execute_in_place_out,
  output logic [1:0]             wrap_mode_out,
  output logic                   quad_protocol_out
);

  // Wrap-aware address step
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                  input logic [1:0] w);
    logic [ADDR_W-1:0] inc;
    inc = a + {{(ADDR_W-1){1'b0}}, 1'b1};
    case (w)
      vrc_pkg::WRAP_16: next_addr = {a[ADDR_W-1:4], inc[3:0]};
      vrc_pkg::WRAP_32: next_addr = {a[ADDR_W-1:5], inc[4:0]};
      vrc_pkg::WRAP_64: next_addr = {a[ADDR_W-1:6], inc[5:0]};
      default:          next_addr = inc;
    endcase
  endfunction

  // Dummy count from code; zero aliases the default
  function automatic logic [4:0] dummy_count(input logic [3:0] cd);
    if (cd == vrc_pkg::DUMMY_ZERO || cd == vrc_pkg::DUMMY_DEF_CD) begin
      dummy_count = vrc_pkg::DUMMY_DEF_N;
    end else begin
      dummy_count = {1'b0, cd};
    end
  endfunction

  // System domain: volatile register and operating configuration
  vrc_pkg::vrc_cfg_t vcfg_q;
  vrc_pkg::vrc_cfg_t vcfg_d;
  vrc_pkg::vrc_cfg_t wr_hold_q;
  logic              cfg_tgl_q;
  logic              wr_pulse;
  logic              wr_tgl_q;
  vrc_pkg::vrc_cfg_t nv_cfg;

  // Nonvolatile fields mapped to the volatile layout
  assign nv_cfg = '{dummy:   nv_cfg_in[vrc_pkg::NV_DUMMY_LSB +: 4],
                    xip_off: (nv_cfg_in[vrc_pkg::NV_XIP_LSB +: 3] == vrc_pkg::NV_XIP_OFF),
                    rsvd:    1'b0,
                    wrap:    vrc_pkg::WRAP_CONT};

  vrc_tog_sync u_wr_sync (
    .clk_in    (clock_in),
    .rst_in    (rst_in),
    .tgl_in    (wr_tgl_q),
    .pulse_out (wr_pulse)
  );

  // Hold word is stable for several edges before the toggle lands
  always_comb begin
    vcfg_d      = vcfg_q;
    if (wr_pulse) begin
      vcfg_d      = wr_hold_q;
      vcfg_d.rsvd = 1'b0;
    end
  end

  // Reset load happens after release so the port is sampled by a clocked edge
  logic boot_q;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      vcfg_q    <= vrc_pkg::vrc_cfg_t'(vrc_pkg::VCFG_RESET);
      boot_q    <= 1'b1;
      cfg_tgl_q <= 1'b0;
    end else begin
      boot_q    <= 1'b0;
      vcfg_q    <= boot_q ? nv_cfg : vcfg_d;
      cfg_tgl_q <= cfg_tgl_q ^ (boot_q | wr_pulse);
    end
  end

  assign dummy_cycles_out     = vcfg_q.dummy;
  assign execute_in_place_out = ~vcfg_q.xip_off;
  assign wrap_mode_out        = vcfg_q.wrap;
  assign quad_protocol_out    = ~nv_cfg_in[vrc_pkg::NV_DUAL_BIT] &
                                ~nv_cfg_in[vrc_pkg::NV_QUAD_BIT];

  // Link domain: reset synchroniser and configuration copy
  logic              lrst_meta_q;
  logic              lrst_q;
  logic              cfg_pulse;
  vrc_pkg::vrc_cfg_t lcfg_q;

  always_ff @(posedge link_clk_in) begin
    lrst_meta_q <= rst_in;
    lrst_q      <= lrst_meta_q;
  end

  vrc_tog_sync u_cfg_sync (
    .clk_in    (link_clk_in),
    .rst_in    (lrst_q),
    .tgl_in    (cfg_tgl_q),
    .pulse_out (cfg_pulse)
  );

  // System word changes only with the toggle, so it is stable when sampled
  always_ff @(posedge link_clk_in) begin
    if (lrst_q) begin
      lcfg_q <= vrc_pkg::vrc_cfg_t'(vrc_pkg::VCFG_RESET);
    end else if (cfg_pulse) begin
      lcfg_q <= vcfg_q;
    end
  end

  // Frame engine; chip select high clears it to constants
  vrc_pkg::vrc_state_t state_q;
  logic [4:0]          cnt_q;
  logic [7:0]          sh_q;
  logic [7:0]          out_q;
  logic [ADDR_W-1:0]   addr_q;
  logic [7:0]          cmd_byte;
  logic [ADDR_W-1:0]   addr_word;
  logic                cnt_last8;
  logic                cnt_last_addr;
  logic                cnt_last_dummy;
  logic [4:0]          dummy_n;
  logic [7:0]          reg_rd;

  assign cmd_byte       = {sh_q[6:0], si_in};
  assign addr_word      = {addr_q[ADDR_W-2:0], si_in};
  assign cnt_last8      = (cnt_q == 5'h07);
  assign cnt_last_addr  = (cnt_q == 5'(ADDR_W - 1));
  assign dummy_n        = dummy_count(lcfg_q.dummy);
  assign cnt_last_dummy = (cnt_q == dummy_n - 5'h01);
  assign reg_rd         = {lcfg_q.dummy, lcfg_q.xip_off, 1'b0, lcfg_q.wrap};

  always_ff @(posedge link_clk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      state_q   <= vrc_pkg::ST_CMD;
      cnt_q     <= 5'h00;
      sh_q      <= 8'h00;
      out_q     <= 8'h00;
      addr_q    <= '0;
    end else begin
      cnt_q <= cnt_q + 5'h01;
      sh_q  <= cmd_byte;
      out_q <= {out_q[6:0], 1'b0};
      case (state_q)
        vrc_pkg::ST_CMD: begin
          if (cnt_last8) begin
            cnt_q <= 5'h00;
            case (cmd_byte)
              vrc_pkg::OP_WR_VCFG: state_q <= vrc_pkg::ST_WREG;
              vrc_pkg::OP_RD_VCFG: begin
                state_q <= vrc_pkg::ST_RREG;
                out_q   <= reg_rd;
              end
              vrc_pkg::OP_FAST_RD: state_q <= vrc_pkg::ST_ADDR;
              vrc_pkg::OP_TUNE_RD: begin
                state_q <= vrc_pkg::ST_TUNE;
                out_q   <= vrc_pkg::TUNE_BYTE;
              end
              default:             state_q <= vrc_pkg::ST_IGN;
            endcase
          end
        end
        vrc_pkg::ST_ADDR: begin
          addr_q <= addr_word;
          if (cnt_last_addr) begin
            cnt_q   <= 5'h00;
            state_q <= vrc_pkg::ST_DUMMY;
          end
        end
        vrc_pkg::ST_DUMMY: begin
          if (cnt_last_dummy) begin
            cnt_q   <= 5'h00;
            state_q <= vrc_pkg::ST_DATA;
            out_q   <= mem_data_in;
            addr_q  <= next_addr(addr_q, lcfg_q.wrap);
          end
        end
        vrc_pkg::ST_DATA: begin
          if (cnt_last8) begin
            cnt_q  <= 5'h00;
            out_q  <= mem_data_in;
            addr_q <= next_addr(addr_q, lcfg_q.wrap);
          end
        end
        vrc_pkg::ST_WREG: begin
          if (cnt_last8) begin
            state_q   <= vrc_pkg::ST_IGN;
          end
        end
        vrc_pkg::ST_RREG: begin
          if (cnt_last8) begin
            cnt_q <= 5'h00;
            out_q <= reg_rd;
          end
        end
        vrc_pkg::ST_TUNE: begin
          if (cnt_last8) begin
            cnt_q <= 5'h00;
            out_q <= vrc_pkg::TUNE_BYTE;
          end
        end
        default: cnt_q <= 5'h00;
      endcase
    end
  end

  // Toggle and hold word must survive chip select; an early deselect must not lose the write
  logic wr_done;
  assign wr_done = ~cs_n_in & (state_q == vrc_pkg::ST_WREG) & cnt_last8;

  always_ff @(posedge link_clk_in) begin
    if (lrst_q) begin
      wr_tgl_q  <= 1'b0;
      wr_hold_q <= vrc_pkg::vrc_cfg_t'(vrc_pkg::VCFG_RESET);
    end else if (wr_done) begin
      wr_tgl_q  <= ~wr_tgl_q;
      wr_hold_q <= vrc_pkg::vrc_cfg_t'(cmd_byte);
    end
  end

  // Too few dummies just means early data; nothing is checked here
  assign so_out       = out_q[7];
  assign so_oe_out    = ~cs_n_in & ((state_q == vrc_pkg::ST_DATA) |
                                    (state_q == vrc_pkg::ST_RREG) |
                                    (state_q == vrc_pkg::ST_TUNE));
  assign mem_addr_out = addr_q;
endmodule

// [vrc_assertions.sv]
// Purpose: Port checks for the read-config block
// Assumes: Link clock much slower than clock_in
// Notes:   Link edges are seen as level changes here
`timescale 1ns/1ps
module vrc_assertions #(
  parameter int ADDR_W = 24
) (
  input wire logic              clock_in,
  input wire logic              rst_in,
  input wire logic [15:0]       nv_cfg_in,
  input wire logic              link_clk_in,
  input wire logic              cs_n_in,
  input wire logic              so_out,
  input wire logic              so_oe_out,
  input wire logic [ADDR_W-1:0] mem_addr_out,
  input wire logic [3:0]        dummy_cycles_out,
  input wire logic              execute_in_place_out,
  input wire logic [1:0]        wrap_mode_out,
  input wire logic              quad_protocol_out
);
  sequence s_release;
    $fell(rst_in);
  endsequence
  // Long enough to cover the crossing delay of a write
  sequence s_idle;
    (cs_n_in && !rst_in) [*8];
  endsequence
  property p_reset_def;
    @(posedge clock_in) rst_in |=> (dummy_cycles_out == 4'hF &&
      !execute_in_place_out && wrap_mode_out == 2'h3);
  endproperty
  a_reset_def: assert property (p_reset_def) else $error("reset config wrong");
  property p_nv_load;
    @(posedge clock_in) disable iff (rst_in) s_release |-> ##[1:2]
      (dummy_cycles_out == nv_cfg_in[15:12] && wrap_mode_out == 2'h3);
  endproperty
  a_nv_load: assert property (p_nv_load) else $error("nv load wrong");
  property p_xip_load;
    @(posedge clock_in) disable iff (rst_in) s_release |-> ##[1:2]
      (execute_in_place_out == (nv_cfg_in[11:9] != 3'h7));
  endproperty
  a_xip_load: assert property (p_xip_load) else $error("xip load wrong");
  property p_idle_stable;
    @(posedge clock_in) disable iff (rst_in) s_idle |=> ($stable(dummy_cycles_out) &&
      $stable(execute_in_place_out) && $stable(wrap_mode_out));
  endproperty
  a_idle_stable: assert property (p_idle_stable) else $error("config moved");
  property p_oe_off;
    @(posedge clock_in) disable iff (rst_in) cs_n_in |-> !so_oe_out;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("driving unselected");
  property p_so_edge;
    @(posedge clock_in) disable iff (rst_in)
      $changed(so_out) |-> ($rose(link_clk_in) || $rose(cs_n_in));
  endproperty
  a_so_edge: assert property (p_so_edge) else $error("data off edge");
  property p_addr_edge;
    @(posedge clock_in) disable iff (rst_in)
      $changed(mem_addr_out) |-> ($rose(link_clk_in) || $rose(cs_n_in));
  endproperty
  a_addr_edge: assert property (p_addr_edge) else $error("addr off edge");
  property p_quad;
    @(posedge clock_in) disable iff (rst_in)
      quad_protocol_out == (nv_cfg_in[3:2] == 2'h0);
  endproperty
  a_quad: assert property (p_quad) else $error("protocol wrong");
endmodule

// [vrc_host_model.sv]
// Purpose: Serial host driving the link
// Assumes: Mode 0, 64 ns link period
// Notes:   Clock stands low between frames
`timescale 1ns/1ps
module vrc_host_model (
  output logic      link_clk_out,
  output logic      cs_n_out,
  output logic      si_out,
  input  wire logic so_in,
  input  wire logic so_oe_in
);
  initial begin
    link_clk_out = 1'b0;
    cs_n_out     = 1'b1;
    si_out       = 1'b0;
  end
  // Rate well under every dummy limit
  task automatic idle(input int n);
    repeat (n) begin
      #32 link_clk_out = 1'b1;
      #32 link_clk_out = 1'b0;
    end
  endtask
  task automatic frame(input logic [63:0] tx, input int nt, input int nr,
                       output logic [63:0] rx);
    rx = '0;
    cs_n_out = 1'b0;
    for (int i = nt - 1; i >= 0; i--) begin
      si_out = tx[i];
      idle(1);
    end
    for (int i = 0; i < nr; i++) begin
      // Undriven line reads as the inverse, so a missing enable shows up
      rx = {rx[62:0], (so_oe_in ? so_in : ~so_in)};
      idle(1);
    end
    #32 cs_n_out = 1'b1;
    si_out = ~si_out;
    // Deselect gap so back-to-back frames never glitch chip select
    #64;
  endtask
endmodule

// [tb.sv]
// Purpose: Self-checking bench for the read-config block
// Assumes: Array byte is address xor 5A
// Notes:   Reset spans link edges so the link side clears
`timescale 1ns/1ps
module tb;
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [15:0] nv_cfg_in = 16'hFFFF;
  logic        lclk, cs_n, si, so, oe, execute_in_place, quad;
  logic [23:0] addr;
  logic [3:0]  dummy;
  logic [1:0]  wrap;
  logic [63:0] rx;
  int          num_errors = 0;
  int          checks_done = 0;
  wire  [7:0]  mem = addr[7:0] ^ 8'h5A;
  always #5 clock_in = ~clock_in;
  vrc_volatile_read_config dut (.clock_in(clock_in), .rst_in(rst_in),
    .nv_cfg_in(nv_cfg_in), .link_clk_in(lclk), .cs_n_in(cs_n), .si_in(si),
    .so_out(so), .so_oe_out(oe), .mem_addr_out(addr), .mem_data_in(mem),
    .dummy_cycles_out(dummy), .execute_in_place_out(execute_in_place),
    .wrap_mode_out(wrap), .quad_protocol_out(quad));
  vrc_host_model host (.link_clk_out(lclk), .cs_n_out(cs_n), .si_out(si),
    .so_in(so), .so_oe_in(oe));
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic t_reset(input logic [15:0] nv);
    @(posedge clock_in) #1;
    rst_in = 1'b1;
    nv_cfg_in = nv;
    host.idle(3);
    cmp({dummy, execute_in_place, wrap}, 7'h7B);
    @(posedge clock_in) #1;
    rst_in = 1'b0;
    repeat (3) @(posedge clock_in);
    #1 cmp({dummy, execute_in_place, wrap}, {nv[15:12], nv[11:9] != 3'h7, 2'h3});
    cmp(quad, nv[3:2] == 2'h0);
    nv_cfg_in = ~nv;
    #1 cmp(dummy, nv[15:12]);
    host.idle(4);
  endtask
  // Trailing byte must not disturb the register
  task automatic t_reg(input logic [7:0] val);
    logic [7:0] exp;
    exp = val & 8'hFB;
    host.frame({40'h0, vrc_pkg::OP_WR_VCFG, val, 8'hFF}, 24, 0, rx);
    repeat (8) @(posedge clock_in);
    #1 cmp({execute_in_place, wrap}, {~exp[3], exp[1:0]});
    cmp(dummy, exp[7:4]);
    host.frame({56'h0, vrc_pkg::OP_RD_VCFG}, 8, 16, rx);
    cmp(rx[15:0], {exp, exp});
  endtask
  task automatic t_fast(input logic [3:0] code, input logic [1:0] wm);
    int          n;
    int          sz;
    logic [23:0] a;
    logic [31:0] exp;
    n = (code == 4'h0 || code == 4'hF) ? 8 : code;
    sz = (wm == 2'h3) ? 0 : 16 << wm;
    exp = '0;
    t_reg({code, 2'h2, wm});
    for (int i = 0; i < 4; i++) begin
      a = 24'h3D + i;
      if (sz != 0)
        a = (24'h3D & ~(sz - 1)) | (a & (sz - 1));
      exp = {exp[23:0], a[7:0] ^ 8'h5A};
    end
    host.frame({32'h0, vrc_pkg::OP_FAST_RD, 24'h3D} << n, 32 + n, 32, rx);
    cmp(rx[31:0], exp);
  endtask
  task automatic t_tune;
    host.frame({56'h0, vrc_pkg::OP_TUNE_RD}, 8, 16, rx);
    cmp(rx[15:0], {2{vrc_pkg::TUNE_BYTE}});
  endtask
  initial begin
    #200000;
    num_errors++;
    close_out();
  end
  initial begin
    t_reset(16'h5FF7);
    t_reg(8'hA4);
    t_fast(4'h0, 2'h0);
    t_fast(4'h1, 2'h1);
    t_fast(4'hE, 2'h2);
    t_fast(4'hF, 2'h3);
    t_tune();
    t_reset(16'h3133);
    close_out();
  end
endmodule
bind vrc_volatile_read_config vrc_assertions #(.ADDR_W(ADDR_W)) chk (
  .clock_in(clock_in), .rst_in(rst_in), .nv_cfg_in(nv_cfg_in),
  .link_clk_in(link_clk_in), .cs_n_in(cs_n_in), .so_out(so_out),
  .so_oe_out(so_oe_out), .mem_addr_out(mem_addr_out),
  .dummy_cycles_out(dummy_cycles_out), .execute_in_place_out(execute_in_place_out),
  .wrap_mode_out(wrap_mode_out), .quad_protocol_out(quad_protocol_out));
